// ===== verilog/tdc_pkg.sv
// Shared constants and types for the Tx loop control and status block
package tdc_pkg;

  // Tx loop modes, in the two-bit order used by both the pins and the mode register
  typedef enum logic [1:0] {TDC_AUTO, TDC_NORMAL, TDC_HOLDOVER, TDC_FREERUN} tdc_mode_t;

  // Register offsets
  localparam logic [7:0] REG_TX_MODE = 8'h1F;
  localparam logic [7:0] REG_HITLESS = 8'h20;
  localparam logic [7:0] REG_SYN1_N_LO = 8'h21;
  localparam logic [7:0] REG_SYN1_N_HI = 8'h22;
  localparam logic [7:0] REG_SYN1_SEC = 8'h23;
  localparam logic [7:0] REG_FP_STYLE = 8'h24;

  // Field positions
  localparam int MODE_LSB = 0;
  localparam int HOLD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam int HS_VALUE_BIT = 0;
  localparam int HS_OVERRIDE_BIT = 1;
  localparam int HS_ACTIVE_BIT = 7;
  localparam int SEC_DIV_BIT = 7;
  localparam int SEC_FACTOR_MSB = 3;
  localparam int N_HI_MSB = 5;

  // Reset values
  localparam logic [13:0] SYN1_N_RESET = 14'h00C1;
  localparam logic [7:0] SYN1_SEC_RESET = 8'h02;
  localparam logic [1:0] FP_STYLE_RESET = 2'h0;
  localparam logic [7:0] HITLESS_RESET = 8'h00;

  // Frequency words for a 32-bit accumulator on a 125 MHz clock
  localparam logic [31:0] FCW_8K = 32'h0004_31BE;
  localparam logic [31:0] FCW_2K = 32'h0001_0C6F;
  localparam logic [13:0] SYN1_N_MAX = 14'h30D4;

  // Frame pulse styles
  localparam logic [1:0] FP_PULSE_HIGH = 2'h0;
  localparam logic [1:0] FP_PULSE_LOW = 2'h1;
  localparam logic [1:0] FP_SQUARE = 2'h2;

endpackage

// ===== verilog/tdc_nco.sv
// Phase accumulator that turns a frequency word into a clock and a wrap pulse
`timescale 1ns/1ps
module tdc_nco
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] fcw,
  output logic clk_q,
  output logic wrap_q
);

  logic [31:0] acc_q;
  logic [32:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, fcw};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_q <= '0;
      clk_q <= 1'b0;
      wrap_q <= 1'b0;
    end
    else
    begin
      acc_q <= sum[31:0];
      clk_q <= sum[31];
      wrap_q <= sum[32];
    end
  end

endmodule

// ===== verilog/tdc_regfile.sv
// Register file behind the serial-interface register port
`timescale 1ns/1ps
module tdc_regfile
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] tx_mode,
  input wire logic lock,
  input wire logic hold,
  input wire logic hitless_active,
  output logic [7:0] reg_rdata_q,
  output logic mode_wr,
  output logic [7:0] hitless_q,
  output logic [13:0] syn1_n_q,
  output logic [7:0] syn1_sec_q,
  output logic [1:0] fp_style_q
);

  logic [7:0] rdata_d;
  logic [7:0] mode_rd;
  logic [7:0] hs_rd;
  logic sel_mode, sel_hs, sel_nlo, sel_nhi, sel_sec, sel_fp;

  assign sel_mode = reg_addr == tdc_pkg::REG_TX_MODE;
  assign sel_hs = reg_addr == tdc_pkg::REG_HITLESS;
  assign sel_nlo = reg_addr == tdc_pkg::REG_SYN1_N_LO;
  assign sel_nhi = reg_addr == tdc_pkg::REG_SYN1_N_HI;
  assign sel_sec = reg_addr == tdc_pkg::REG_SYN1_SEC;
  assign sel_fp = reg_addr == tdc_pkg::REG_FP_STYLE;
  assign mode_wr = reg_wr_en && sel_mode && !rst;

  // Mode register reads back the live mode with lock and holdover status
  assign mode_rd = {lock, hold, 4'h0, tx_mode};
  assign hs_rd = {hitless_active, 5'h00, hitless_q[tdc_pkg::HS_OVERRIDE_BIT],
    hitless_q[tdc_pkg::HS_VALUE_BIT]};
  assign rdata_d = sel_mode ? mode_rd :
                   sel_hs ? hs_rd :
                   sel_nlo ? syn1_n_q[7:0] :
                   sel_nhi ? {2'h0, syn1_n_q[13:8]} :
                   sel_sec ? syn1_sec_q :
                   sel_fp ? {6'h00, fp_style_q} : 8'h00;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata_q <= 8'h00;
      hitless_q <= tdc_pkg::HITLESS_RESET;
      syn1_n_q <= tdc_pkg::SYN1_N_RESET;
      syn1_sec_q <= tdc_pkg::SYN1_SEC_RESET;
      fp_style_q <= tdc_pkg::FP_STYLE_RESET;
    end
    else
    begin
      reg_rdata_q <= reg_rd_en ? rdata_d : 8'h00;
      if (reg_wr_en && sel_hs)
        hitless_q <= {6'h00, reg_wdata[1:0]};
      if (reg_wr_en && sel_nlo)
        syn1_n_q[7:0] <= reg_wdata;
      if (reg_wr_en && sel_nhi)
        syn1_n_q[13:8] <= reg_wdata[tdc_pkg::N_HI_MSB:0];
      if (reg_wr_en && sel_sec)
        syn1_sec_q <= reg_wdata;
      if (reg_wr_en && sel_fp)
        fp_style_q <= reg_wdata[1:0];
    end
  end

endmodule

// ===== verilog/tdc_ctrl.sv
// Tx loop pin control, status indicators, reference copy and synthesizer defaults
`timescale 1ns/1ps
// Operation
// - Holding reset puts every output and control state into its reset value.
// - Hitless enable high lets the Tx loop switch references without a phase step.
// - Hitless enable low disables it and realigns output phase to the selected reference.
// - Software can also set hitless switching through a register.
// - Mode select pins are sampled during reset as the default Tx loop mode.
// - After reset the mode follows the pins or writes to the mode register.
// - Each driver enable turns its differential driver on, low tristates it.
// - Lock goes high when the loop is frequency and phase locked, except in holdover or free-run.
// - Holdover indicator goes high when the Tx loop is in holdover.
// - Selected-reference output copies the clock the Rx selector passes.
// - The selected-reference copy may step in phase on a reference change.
// - Synthesizer 1 primary clock is 2 kHz or N times 8 kHz, default 1.544 MHz.
// - Synthesizer 1 secondary clock multiplies or divides the primary, default 3.088 MHz.
// - Synthesizer 0 second frame pulse has selectable style, default 8 kHz rate.
module tdc_ctrl
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode_select0,
  input wire logic mode_select1,
  input wire logic hitless_switch_enable,
  input wire logic lvpecl_driver0_enable,
  input wire logic lvpecl_driver1_enable,
  input wire logic [7:0] ref_in,
  input wire logic [2:0] rx_ref_select,
  input wire logic ref_switch,
  input wire logic ref_lost,
  input wire logic loop_freq_locked,
  input wire logic loop_phase_locked,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic [1:0] tx_mode_q,
  output logic hitless_active_q,
  output logic phase_realign_q,
  output logic lvpecl_drv0_on_q,
  output logic lvpecl_drv1_on_q,
  output logic lock_q,
  output logic hold_q,
  output logic ref_out_q,
  output logic synth1_primary_clock,
  output logic synth1_secondary_clock,
  output logic synth0_second_frame_pulse
);

  logic mode_wr;
  logic [7:0] hitless_q;
  logic [13:0] syn1_n_q;
  logic [7:0] syn1_sec_q;
  logic [1:0] fp_style_q;
  logic [1:0] pins_prev_q;
  logic [1:0] pins_now;
  logic [1:0] mode_d;
  logic pins_changed;
  tdc_pkg::tdc_mode_t mode_e;
  logic hs_eff;
  logic hs_drop;
  logic lock_d;
  logic hold_d;
  logic [13:0] n_eff;
  logic [31:0] fcw_prim;
  logic [31:0] fcw_sec;
  logic [45:0] prim_prod;
  logic [35:0] sec_prod;
  logic [3:0] sec_factor;
  logic fp_clk;
  logic fp_wrap;
  logic fp_d;
  logic fp_q;

  tdc_regfile u_regs
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata),
    .tx_mode(tx_mode_q),
    .lock(lock_q),
    .hold(hold_q),
    .hitless_active(hitless_active_q),
    .reg_rdata_q(reg_rdata_q),
    .mode_wr(mode_wr),
    .hitless_q(hitless_q),
    .syn1_n_q(syn1_n_q),
    .syn1_sec_q(syn1_sec_q),
    .fp_style_q(fp_style_q)
  );

  // Mode source: register write wins over a same-cycle pin change
  assign pins_now = {mode_select1, mode_select0};
  assign pins_changed = pins_now != pins_prev_q;
  assign mode_d = rst ? pins_now :
                  mode_wr ? reg_wdata[tdc_pkg::MODE_LSB +: 2] :
                  pins_changed ? pins_now : tx_mode_q;
  assign mode_e = tdc_pkg::tdc_mode_t'(tx_mode_q);

  always_ff @(posedge ref_clk)
  begin
    tx_mode_q <= mode_d;
    pins_prev_q <= pins_now;
  end

  // Hitless switching: software override takes the pin's place when set
  assign hs_eff = hitless_q[tdc_pkg::HS_OVERRIDE_BIT] ?
    hitless_q[tdc_pkg::HS_VALUE_BIT] : hitless_switch_enable;
  // Realign on leaving hitless mode, and on any reference switch while disabled
  assign hs_drop = !hs_eff && (hitless_active_q || ref_switch);

  // Indicators: holdover in forced holdover or when auto mode loses its reference
  assign hold_d = (mode_e == tdc_pkg::TDC_HOLDOVER) ||
    ((mode_e == tdc_pkg::TDC_AUTO) && ref_lost);
  assign lock_d = loop_freq_locked && loop_phase_locked && !hold_d &&
    (mode_e != tdc_pkg::TDC_FREERUN);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hitless_active_q <= 1'b0;
      phase_realign_q <= 1'b0;
      lvpecl_drv0_on_q <= 1'b0;
      lvpecl_drv1_on_q <= 1'b0;
      lock_q <= 1'b0;
      hold_q <= 1'b0;
      ref_out_q <= 1'b0;
    end
    else
    begin
      hitless_active_q <= hs_eff;
      phase_realign_q <= hs_drop;
      lvpecl_drv0_on_q <= lvpecl_driver0_enable;
      lvpecl_drv1_on_q <= lvpecl_driver1_enable;
      lock_q <= lock_d;
      hold_q <= hold_d;
      // Plain mux: a selector change passes straight through, phase step included
      ref_out_q <= ref_in[rx_ref_select];
    end
  end

  // Synthesizer 1: N of zero gives 2 kHz, N above the 100 MHz limit is clamped
  assign n_eff = (syn1_n_q > tdc_pkg::SYN1_N_MAX) ? tdc_pkg::SYN1_N_MAX : syn1_n_q;
  assign prim_prod = {32'h0000_0000, n_eff} * {14'h0000, tdc_pkg::FCW_8K};
  assign fcw_prim = (n_eff == 14'h0000) ? tdc_pkg::FCW_2K : prim_prod[31:0];
  assign sec_factor = syn1_sec_q[tdc_pkg::SEC_FACTOR_MSB:0];
  assign sec_prod = {4'h0, fcw_prim} * {32'h0000_0000, sec_factor};
  assign fcw_sec = syn1_sec_q[tdc_pkg::SEC_DIV_BIT] ? (fcw_prim >> sec_factor) :
    sec_prod[31:0];

  tdc_nco u_syn1_prim
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .fcw(fcw_prim),
    .clk_q(synth1_primary_clock),
    .wrap_q()
  );

  tdc_nco u_syn1_sec
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .fcw(fcw_sec),
    .clk_q(synth1_secondary_clock),
    .wrap_q()
  );

  tdc_nco u_fp
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .fcw(tdc_pkg::FCW_8K),
    .clk_q(fp_clk),
    .wrap_q(fp_wrap)
  );

  // Frame pulse shaping at 8 kHz: one-cycle high, one-cycle low, or square
  assign fp_d = (fp_style_q == tdc_pkg::FP_PULSE_HIGH) ? fp_wrap :
                (fp_style_q == tdc_pkg::FP_PULSE_LOW) ? !fp_wrap :
                (fp_style_q == tdc_pkg::FP_SQUARE) ? fp_clk : fp_wrap;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fp_q <= 1'b0;
    else
      fp_q <= fp_d;
  end

  assign synth0_second_frame_pulse = fp_q;

  default clocking cb @(posedge ref_clk); endclocking

  reset_state_a: assert property (
    rst |=> !lock_q && !hold_q && !lvpecl_drv0_on_q && !hitless_active_q)
    else $error("outputs not at reset value after reset");

  mode_capture_a: assert property (
    rst |=> tx_mode_q == $past(pins_now))
    else $error("mode pins not captured during reset");

  mode_reg_a: assert property (
    disable iff (rst) reg_wr_en && reg_addr == tdc_pkg::REG_TX_MODE
    |=> tx_mode_q == $past(reg_wdata[1:0]))
    else $error("mode register write not applied");

  mode_pin_a: assert property (
    disable iff (rst) !(reg_wr_en && reg_addr == tdc_pkg::REG_TX_MODE) && pins_changed
    |=> tx_mode_q == $past(pins_now))
    else $error("mode pin change not applied");

  hitless_on_a: assert property (
    disable iff (rst) hs_eff ##1 hs_eff |-> hitless_active_q && !phase_realign_q)
    else $error("hitless enable not followed");

  realign_pulse_a: assert property (
    disable iff (rst) hitless_active_q && !hs_eff |=> phase_realign_q && !hitless_active_q)
    else $error("no realign when hitless switching dropped");

  driver_en_a: assert property (
    disable iff (rst) 1'b1 |=> lvpecl_drv1_on_q == $past(lvpecl_driver1_enable))
    else $error("driver enable not followed");

  lock_high_a: assert property (
    disable iff (rst) loop_freq_locked && loop_phase_locked &&
    mode_e == tdc_pkg::TDC_NORMAL |=> lock_q)
    else $error("lock missing while locked in normal mode");

  lock_low_a: assert property (
    disable iff (rst) mode_e == tdc_pkg::TDC_FREERUN || !loop_phase_locked |=> !lock_q)
    else $error("lock high while not locked");

  hold_ind_a: assert property (
    disable iff (rst) mode_e == tdc_pkg::TDC_HOLDOVER |=> hold_q && !lock_q)
    else $error("holdover indicator missing");

  ref_copy_a: assert property (
    disable iff (rst) 1'b1 |=> ref_out_q == $past(ref_in[rx_ref_select]))
    else $error("selected reference not copied");

  drv0_en_a: assert property (
    disable iff (rst) 1'b1 |=> lvpecl_drv0_on_q == $past(lvpecl_driver0_enable))
    else $error("driver 0 enable not followed");

  realign_switch_a: assert property (
    disable iff (rst) !hs_eff && ref_switch |=> phase_realign_q)
    else $error("no realign on reference switch while disabled");

  hitless_reg_a: assert property (
    disable iff (rst) hitless_q[tdc_pkg::HS_OVERRIDE_BIT]
    |=> hitless_active_q == $past(hitless_q[tdc_pkg::HS_VALUE_BIT]))
    else $error("hitless register override not applied");

  hitless_pin_a: assert property (
    disable iff (rst) !hitless_q[tdc_pkg::HS_OVERRIDE_BIT]
    |=> hitless_active_q == $past(hitless_switch_enable))
    else $error("hitless pin not followed");

  hold_auto_a: assert property (
    disable iff (rst) mode_e == tdc_pkg::TDC_AUTO && ref_lost |=> hold_q)
    else $error("holdover missing after reference loss");

  hold_clear_a: assert property (
    disable iff (rst) mode_e == tdc_pkg::TDC_NORMAL |=> !hold_q)
    else $error("holdover high in normal mode");

  lock_freq_a: assert property (
    disable iff (rst) !loop_freq_locked |=> !lock_q)
    else $error("lock high without frequency lock");

  lock_hold_a: assert property (
    disable iff (rst) hold_d |=> !lock_q)
    else $error("lock high in holdover");

  mode_read_a: assert property (
    disable iff (rst) reg_rd_en && reg_addr == tdc_pkg::REG_TX_MODE
    |=> reg_rdata_q[1:0] == $past(tx_mode_q))
    else $error("mode register read differs from live mode");

  rd_idle_a: assert property (
    disable iff (rst) !reg_rd_en |=> reg_rdata_q == 8'h00)
    else $error("read data not cleared when idle");

  ref_step_a: assert property (
    disable iff (rst) $changed(rx_ref_select) |=> ref_out_q == $past(ref_in[rx_ref_select]))
    else $error("reference copy late after selector change");

  syn1_dflt_a: assert property (
    rst |=> syn1_n_q == tdc_pkg::SYN1_N_RESET)
    else $error("synthesizer 1 multiplier not at default");

  sec_dflt_a: assert property (
    rst |=> syn1_sec_q == tdc_pkg::SYN1_SEC_RESET)
    else $error("secondary clock setting not at default");

  fp_dflt_a: assert property (
    rst |=> fp_style_q == tdc_pkg::FP_STYLE_RESET)
    else $error("frame pulse style not at default");

  fp_pulse_a: assert property (
    disable iff (rst) fp_style_q == tdc_pkg::FP_PULSE_HIGH && fp_wrap
    |=> synth0_second_frame_pulse)
    else $error("frame pulse missing on frame wrap");

endmodule

// ===== testbench/tdc_board_model.sv
// Board-side reference clock sources feeding the Tx loop control block
`timescale 1ns/1ps
module tdc_board_model
(
  input wire logic ref_clk,
  output logic [7:0] ref_in
);
  logic [7:0] cnt_q = 8'h00;

  // Each reference toggles in its own pattern so a wrong selection shows up
  always @(posedge ref_clk)
    cnt_q <= #1 cnt_q + 8'h01;

  assign ref_in = {cnt_q[7:1] ^ cnt_q[6:0], cnt_q[0]};
endmodule

// ===== testbench/tx_dpll_control_status_pins_bench.sv
// Self-checking bench for the Tx loop pin control and status block
`timescale 1ns/1ps
module tx_dpll_control_status_pins_bench;
  logic ref_clk, rst, mode_select0, mode_select1, hitless_switch_enable;
  logic lvpecl_driver0_enable, lvpecl_driver1_enable, ref_switch, ref_lost;
  logic loop_freq_locked, loop_phase_locked, reg_wr_en, reg_rd_en;
  logic [7:0] ref_in, reg_addr, reg_wdata, reg_rdata_q, d;
  logic [2:0] rx_ref_select, cur, prv;
  logic [1:0] tx_mode_q;
  logic hitless_active_q, phase_realign_q, lvpecl_drv0_on_q, lvpecl_drv1_on_q;
  logic lock_q, hold_q, ref_out_q, synth1_primary_clock, synth1_secondary_clock;
  logic synth0_second_frame_pulse, exp_b, seen;
  int n_errors = 0;
  int checked = 0;
  int n_p, n_s, n_f;
  // Row: mode pins, ref lost, freq lock, phase lock, drv0, drv1, hold, lock
  logic [8:0] rows [6] = '{9'h039, 9'h076, 9'h0BD, 9'h0A0, 9'h13A, 9'h1B4};

  tdc_board_model board (.ref_clk(ref_clk), .ref_in(ref_in));

  tdc_ctrl dut (.ref_clk, .rst, .mode_select0, .mode_select1, .hitless_switch_enable,
    .lvpecl_driver0_enable, .lvpecl_driver1_enable, .ref_in, .rx_ref_select,
    .ref_switch, .ref_lost, .loop_freq_locked, .loop_phase_locked, .reg_addr,
    .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata_q, .tx_mode_q, .hitless_active_q,
    .phase_realign_q, .lvpecl_drv0_on_q, .lvpecl_drv1_on_q, .lock_q, .hold_q,
    .ref_out_q, .synth1_primary_clock, .synth1_secondary_clock,
    .synth0_second_frame_pulse);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic chk_cnt(input string n, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    {reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
    tick;
    reg_wr_en = 1'b0;
    tick;
  endtask

  // Leaves the read answer in d
  task automatic reg_rd(input logic [7:0] a);
    {reg_addr, reg_rd_en} = {a, 1'b1};
    tick;
    reg_rd_en = 1'b0;
    d = reg_rdata_q;
    tick;
  endtask

  // The pulse may already stand when the caller's own edge launched it
  task automatic see_realign(input logic e);
    seen = (phase_realign_q === 1'b1);
    repeat (4)
    begin
      tick;
      if (phase_realign_q === 1'b1)
        seen = 1'b1;
    end
    chk1("realign", e, seen);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {rst, mode_select1, mode_select0, hitless_switch_enable} = 4'hD;
    {lvpecl_driver0_enable, lvpecl_driver1_enable, loop_freq_locked} = 3'h7;
    {loop_phase_locked, ref_switch, ref_lost, reg_wr_en, reg_rd_en} = 5'h10;
    {reg_addr, reg_wdata, rx_ref_select} = 19'h00000;
    repeat (8) tick;
    chk1("lock_in_rst", 1'b0, lock_q);
    chk1("drv0_in_rst", 1'b0, lvpecl_drv0_on_q);
    rst = 1'b0;
    tick;
    chk8("mode_dflt", 8'h02, {6'h00, tx_mode_q});
    for (int i = 0; i < 6; i++)
    begin
      {mode_select1, mode_select0, ref_lost, loop_freq_locked} = rows[i][8:5];
      {loop_phase_locked, lvpecl_driver0_enable, lvpecl_driver1_enable} = rows[i][4:2];
      repeat (3) tick;
      chk8("mode", {6'h00, rows[i][8:7]}, {6'h00, tx_mode_q});
      chk1("drv0", rows[i][3], lvpecl_drv0_on_q);
      chk1("drv1", rows[i][2], lvpecl_drv1_on_q);
      chk1("hold", rows[i][1], hold_q);
      chk1("lock", rows[i][0], lock_q);
    end
    {ref_lost, loop_freq_locked, loop_phase_locked} = 3'h3;
    reg_wr(tdc_pkg::REG_TX_MODE, 8'h01);
    chk8("mode_reg", 8'h01, {6'h00, tx_mode_q});
    reg_rd(tdc_pkg::REG_TX_MODE);
    chk8("rd_mode", 8'h81, d);
    reg_wr(tdc_pkg::REG_TX_MODE, 8'h02);
    tick;
    reg_rd(tdc_pkg::REG_TX_MODE);
    chk8("rd_hold", 8'h42, d);
    reg_rd(8'h30);
    chk8("rd_unmapped", 8'h00, d);
    for (int s = 0; s < 8; s++)
    begin
      rx_ref_select = 3'(s);
      tick;
      repeat (4)
      begin
        @(negedge ref_clk);
        exp_b = ref_in[rx_ref_select];
        tick;
        chk1("ref_out", exp_b, ref_out_q);
      end
    end
    chk1("hs_on", 1'b1, hitless_active_q);
    hitless_switch_enable = 1'b0;
    see_realign(1'b1);
    chk1("hs_off", 1'b0, hitless_active_q);
    ref_switch = 1'b1;
    tick;
    ref_switch = 1'b0;
    see_realign(1'b1);
    reg_wr(tdc_pkg::REG_HITLESS, 8'h03);
    reg_rd(tdc_pkg::REG_HITLESS);
    chk1("hs_reg", 1'b1, d[tdc_pkg::HS_ACTIVE_BIT]);
    ref_switch = 1'b1;
    tick;
    ref_switch = 1'b0;
    see_realign(1'b0);
    {rst, mode_select1, mode_select0} = 3'h5;
    repeat (38) tick;
    chk1("lock_rst2", 1'b0, lock_q);
    chk8("mode_rst2", 8'h01, {6'h00, tx_mode_q});
    rst = 1'b0;
    tick;
    reg_rd(tdc_pkg::REG_HITLESS);
    chk8("hs_dflt", tdc_pkg::HITLESS_RESET, d);
    reg_rd(tdc_pkg::REG_SYN1_N_LO);
    chk8("n_dflt", tdc_pkg::SYN1_N_RESET[7:0], d);
    reg_rd(tdc_pkg::REG_SYN1_SEC);
    chk8("sec_dflt", tdc_pkg::SYN1_SEC_RESET, d);
    {n_p, n_s, n_f} = '0;
    prv = 3'h7;
    // 47000 cycles at 125 MHz spans three 8 kHz frames
    repeat (47000)
    begin
      tick;
      cur = {synth0_second_frame_pulse, synth1_secondary_clock, synth1_primary_clock};
      n_p += int'(cur[0] & ~prv[0]);
      n_s += int'(cur[1] & ~prv[1]);
      n_f += int'(cur[2] & ~prv[2]);
      prv = cur;
    end
    chk_cnt("primary", 579, 582, n_p);
    chk_cnt("secondary", 1159, 1163, n_s);
    chk_cnt("frame", 3, 3, n_f);
    reg_wr(tdc_pkg::REG_FP_STYLE, 8'h01);
    tick;
    chk1("fp_low", 1'b1, synth0_second_frame_pulse);
    tally_and_finish;
  end
endmodule
